// ===== logic/msp_event_counter.sv
/*
 * One saturating 4-bit statistics counter with clear-on-read.
 * Assumes inc is already limited to one pulse per packet.
 */
`timescale 1ns/1ps
module msp_event_counter
    import msp_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       clkEn,
    input  wire logic       inc,
    input  wire logic       clr,
    output logic [3:0]      count,
    output logic            atMax
);
    logic [3:0] count_r;
    logic [3:0] count_nxt;
    logic [3:0] base;
    // the read returned the old value, so an increment in the same cycle
    // restarts from zero and is kept
    assign base      = clr ? 4'h0 : count_r;
    assign count_nxt = (inc && base != CNT_MAX) ? base + 4'h1 : base;
    assign count     = count_r;
    // looks at the next value: the flag rises with the count, and a
    // clearing read can never leave a stale full count behind it
    assign atMax     = (count_nxt == CNT_MAX);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_r <= 4'h0;
        end else if (clkEn) begin
            count_r <= count_nxt;
        end
    end
endmodule

// ===== logic/msp_led_select.sv
/*
 * Maps a 3-bit LED select code to one indicator source.
 * Assumes source levels are already synchronised.
 */
`timescale 1ns/1ps
module msp_led_select
    import msp_pkg::*;
(
    input  wire logic [2:0] sel,
    input  wire logic       link10,
    input  wire logic       link100,
    input  wire logic       fullDup,
    input  wire logic       txAct,
    input  wire logic       rxAct,
    output logic            led
);
    always_comb begin
        unique case (sel)
            LED_ANY_LINK: led = link10 | link100;
            LED_RSVD:     led = 1'b0;
            LED_LINK10:   led = link10;
            LED_FULLDUP:  led = fullDup;
            LED_TXRX:     led = txAct | rxAct;
            LED_LINK100:  led = link100;
            LED_RX:       led = rxAct;
            LED_TX:       led = txAct;
        endcase
    end
endmodule

// ===== logic/msp_stats_phy_ctrl.sv
/*
 * Transmit statistics counters, buffer memory information and the
 * receive/PHY control register with PHY mode and LED routing.
 * Assumes per-packet transmit outcome pulses from the MAC on core_clk,
 * PHY-side levels from outside that are synchronised here, and a
 * simple register port with read data one cycle after the read strobe.
 */
`timescale 1ns/1ps
module msp_stats_phy_ctrl
    import msp_pkg::*;
#(
    parameter logic [7:0] MEM_SIZE_UNITS = 8'h04
)(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic [15:0]      regRdData,
    // per-packet transmit outcome, pulse at packet end
    input  wire logic        txPktDone,
    input  wire logic        txSuccess,
    input  wire logic [4:0]  txCollisions,
    input  wire logic        txDeferred,
    input  wire logic        txExcDeferred,
    // buffer manager free page count, in memory units
    input  wire logic [7:0]  memFreeUnits,
    input  wire logic        memFreeValid,
    // PHY side
    input  wire logic        phyAnegEnable,
    input  wire logic        phyCtrlSpeed,
    input  wire logic        phyCtrlDuplex,
    input  wire logic        anegResultSpeed,
    input  wire logic        anegResultDuplex,
    input  wire logic        link10Pin,
    input  wire logic        link100Pin,
    input  wire logic        txActPin,
    input  wire logic        rxActPin,
    output logic             phySpeed100,
    output logic             phyFullDuplex,
    output logic             phyAnegRun,
    output logic             counterRolloverFlag,
    output logic             statsIrq,
    output logic             bufferManagerClearCmd,
    output logic             indicatorOutFirst,
    output logic             indicatorOutSecond
);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [8:0] syncA_r;
    logic [8:0] syncB_r;
    logic [8:0] pinsIn;
    assign pinsIn = {phyAnegEnable, phyCtrlSpeed, phyCtrlDuplex,
                     anegResultSpeed, anegResultDuplex,
                     link10Pin, link100Pin, txActPin, rxActPin};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            syncA_r <= 9'h000;
            syncB_r <= 9'h000;
        end else if (clkEn) begin
            syncA_r <= pinsIn;
            syncB_r <= syncA_r;
        end
    end

    logic phyAnegEn;
    logic phySpdBit;
    logic phyDupBit;
    logic negSpd;
    logic negDup;
    logic lnk10;
    logic lnk100;
    logic txAct;
    logic rxAct;
    assign {phyAnegEn, phySpdBit, phyDupBit, negSpd, negDup,
            lnk10, lnk100, txAct, rxAct} = syncB_r;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic selCnt;
    logic selMem;
    logic selRpc;
    logic selSta;
    logic selCmd;
    logic cntRead;
    assign selCnt  = (regAddr == IDX_EVENT_CNT);
    assign selMem  = (regAddr == IDX_MEM_INFO);
    assign selRpc  = (regAddr == IDX_RX_PHY);
    assign selSta  = (regAddr == IDX_STATUS);
    assign selCmd  = (regAddr == IDX_COMMAND);
    assign cntRead = regRdStb && selCnt;

    // ------------------------------------------------------------------
    // statistics counters
    // ------------------------------------------------------------------
    // one pulse per packet end, so each counter moves at most once
    logic incSngl;
    logic incMult;
    logic incDef;
    logic incExc;
    assign incSngl = txPktDone && txSuccess
                     && (txCollisions == 5'd1);
    assign incMult = txPktDone && (txCollisions >= 5'd2)
                     && (txCollisions <= 5'd16);
    assign incDef  = txPktDone && txDeferred;
    assign incExc  = txPktDone && txExcDeferred;

    logic [3:0] cntSngl;
    logic [3:0] cntMult;
    logic [3:0] cntDef;
    logic [3:0] cntExc;
    logic [3:0] atMax;

    msp_event_counter uCntSngl (
        .core_clk (core_clk), .reset (reset), .clkEn (clkEn),
        .inc (incSngl), .clr (cntRead), .count (cntSngl), .atMax (atMax[0]));
    msp_event_counter uCntMult (
        .core_clk (core_clk), .reset (reset), .clkEn (clkEn),
        .inc (incMult), .clr (cntRead), .count (cntMult), .atMax (atMax[1]));
    msp_event_counter uCntDef (
        .core_clk (core_clk), .reset (reset), .clkEn (clkEn),
        .inc (incDef), .clr (cntRead), .count (cntDef), .atMax (atMax[2]));
    msp_event_counter uCntExc (
        .core_clk (core_clk), .reset (reset), .clkEn (clkEn),
        .inc (incExc), .clr (cntRead), .count (cntExc), .atMax (atMax[3]));

    logic [15:0] cntWord;
    assign cntWord = {cntExc, cntDef, cntMult, cntSngl};

    // rollover flag: atMax follows each counter's next value, and the
    // clearing read zeroes them first, so a read always drops the flag
    logic roll_r;
    logic roll_nxt;
    assign roll_nxt = (|atMax) ? 1'b1 : (cntRead ? 1'b0 : roll_r);

    // ------------------------------------------------------------------
    // memory information
    // ------------------------------------------------------------------
    logic [7:0] memFree_r;
    logic       mmuClr_r;
    logic       mmuClrReq;
    logic [15:0] memWord;
    assign mmuClrReq = regWrStb && selCmd && regWrData[CMD_MMU_CLR_BIT];
    // units are 2K bytes times a multiplier of one
    assign memWord = {memFree_r, MEM_SIZE_UNITS};

    // ------------------------------------------------------------------
    // receive/PHY control
    // ------------------------------------------------------------------
    logic [15:0] rpc_r;
    logic        macAneg;
    logic        autoRun;
    logic        spd_nxt;
    logic        dup_nxt;
    assign macAneg = rpc_r[RPC_MAC_AUTONEG_SELECT_BIT];
    assign autoRun = macAneg && phyAnegEn;
    // manual select: register bits rule; otherwise the PHY decides
    assign spd_nxt = !macAneg ? rpc_r[RPC_SPEED_BIT]
                   : (phyAnegEn ? negSpd : phySpdBit);
    assign dup_nxt = !macAneg ? rpc_r[RPC_DUPLEX_BIT]
                   : (phyAnegEn ? negDup : phyDupBit);

    logic indicator_out_first;
    logic indicator_out_second;
    msp_led_select uLedA (
        .sel (rpc_r[RPC_INDICATOR_OUT_FIRST_LSB +: 3]), .link10 (lnk10), .link100 (lnk100),
        .fullDup (phyFullDuplex), .txAct (txAct), .rxAct (rxAct),
        .led (indicator_out_first));
    msp_led_select uLedB (
        .sel (rpc_r[RPC_INDICATOR_OUT_SECOND_LSB +: 3]), .link10 (lnk10), .link100 (lnk100),
        .fullDup (phyFullDuplex), .txAct (txAct), .rxAct (rxAct),
        .led (indicator_out_second));

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [15:0] rdMux;
    assign rdMux = selCnt ? cntWord
                 : selMem ? memWord
                 : selRpc ? rpc_r
                 : selSta ? {15'h0000, roll_r}
                 : 16'h0000;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rpc_r     <= RPC_RESET;
            roll_r    <= 1'b0;
            mmuClr_r  <= 1'b0;
            regRdData <= 16'h0000;
        end else if (clkEn) begin
            if (regWrStb && selRpc) begin
                rpc_r <= regWrData & RPC_WMASK;
            end
            roll_r    <= roll_nxt;
            mmuClr_r  <= mmuClrReq;
            // data stand only in the cycle after the strobe
            regRdData <= regRdStb ? rdMux : 16'h0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            memFree_r <= MEM_SIZE_UNITS;
        end else if (clkEn) begin
            if (mmuClrReq) begin
                memFree_r <= MEM_SIZE_UNITS;
            end else if (memFreeValid) begin
                memFree_r <= memFreeUnits;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            phySpeed100           <= 1'b0;
            phyFullDuplex         <= 1'b0;
            phyAnegRun            <= 1'b0;
            statsIrq              <= 1'b0;
            bufferManagerClearCmd <= 1'b0;
            indicatorOutFirst     <= 1'b0;
            indicatorOutSecond    <= 1'b0;
        end else if (clkEn) begin
            phySpeed100           <= spd_nxt;
            phyFullDuplex         <= dup_nxt;
            phyAnegRun            <= autoRun;
            statsIrq              <= roll_nxt;
            bufferManagerClearCmd <= mmuClrReq;
            indicatorOutFirst     <= indicator_out_first;
            indicatorOutSecond    <= indicator_out_second;
        end
    end

    assign counterRolloverFlag = roll_r;

endmodule

// ===== shared/msp_pkg.sv
/*
 * Package for the transmit statistics and PHY mode control register group:
 * register indexes, field positions, reset values, LED source codes.
 * Assumes a 16-bit register port with word indexes as addresses.
 */
// Functional notes
// - four 4-bit transmit statistics counters
// - interrupt when any counter reaches 15
// - reading counters clears all four
// - counters saturate at 15, never wrap
// - at most one increment per packet
// - single collision success bumps single count
// - two to sixteen collisions bump multiple count
// - deferred packet bumps deferral count once
// - free memory reset to total size
// - memory reported in 2K units, multiplier one
// - manual mode speed bit sets PHY speed
// - autoneg select ignores speed bit
// - manual mode duplex bit sets PHY duplex
// - autoneg select ignores duplex bit
// - autoneg only when both enable bits set
// - LED select fields route link sources
// - rollover flag set at 15, read clears
package msp_pkg;

    // ------------------------------------------------------------------
    // register indexes
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_EVENT_CNT = 4'h6;
    localparam logic [3:0] IDX_MEM_INFO  = 4'h8;
    localparam logic [3:0] IDX_RX_PHY    = 4'ha;
    localparam logic [3:0] IDX_STATUS    = 4'hc;
    localparam logic [3:0] IDX_COMMAND   = 4'he;

    // ------------------------------------------------------------------
    // fields
    // ------------------------------------------------------------------
    localparam int CNT_EXC_DEF_LSB = 12;
    localparam int CNT_DEF_LSB     = 8;
    localparam int CNT_MULT_LSB    = 4;
    localparam int CNT_SNGL_LSB    = 0;
    localparam logic [3:0] CNT_MAX = 4'hf;

    localparam int RPC_SPEED_BIT  = 13;
    localparam int RPC_DUPLEX_BIT = 12;
    localparam int RPC_MAC_AUTONEG_SELECT_BIT   = 11;
    localparam int RPC_INDICATOR_OUT_FIRST_LSB   = 5;
    localparam int RPC_INDICATOR_OUT_SECOND_LSB   = 2;
    localparam logic [15:0] RPC_WMASK = 16'h38fc;
    localparam logic [15:0] RPC_RESET = 16'h0000;

    localparam int MEM_FREE_LSB  = 8;
    localparam int MEM_TOTAL_LSB = 0;
    localparam int MEM_UNIT_BYTES = 2048;
    localparam int MEM_MULT       = 1;

    localparam int STA_ROLL_BIT   = 0;
    localparam int CMD_MMU_CLR_BIT = 0;

    // ------------------------------------------------------------------
    // LED source codes
    // ------------------------------------------------------------------
    localparam logic [2:0] LED_ANY_LINK = 3'h0;
    localparam logic [2:0] LED_RSVD     = 3'h1;
    localparam logic [2:0] LED_LINK10   = 3'h2;
    localparam logic [2:0] LED_FULLDUP  = 3'h3;
    localparam logic [2:0] LED_TXRX     = 3'h4;
    localparam logic [2:0] LED_LINK100  = 3'h5;
    localparam logic [2:0] LED_RX       = 3'h6;
    localparam logic [2:0] LED_TX       = 3'h7;

endpackage

// ===== tb/msp_phy_model.sv
/*
 * Stand-in for the internal PHY's mode and link levels.
 * Assumes the bench sets a command word; levels follow after an edge.
 */
`timescale 1ns/1ps
module msp_phy_model (
    input  wire logic       core_clk,
    input  wire logic [8:0] cmd,
    output logic            phyAnegEnable,
    output logic            phyCtrlSpeed,
    output logic            phyCtrlDuplex,
    output logic            anegResultSpeed,
    output logic            anegResultDuplex,
    output logic            link10Pin,
    output logic            link100Pin,
    output logic            txActPin,
    output logic            rxActPin
);
    // levels move just after an edge, as a real PHY launches them
    always_ff @(posedge core_clk) begin
        {phyAnegEnable, phyCtrlSpeed, phyCtrlDuplex, anegResultSpeed,
         anegResultDuplex, link10Pin, link100Pin, txActPin,
         rxActPin} <= cmd;
    end
endmodule

// ===== tb/msp_stats_phy_ctrl_properties.sv
/*
 * Checker for the statistics and PHY control block, bound to its top.
 * Assumes it sees only the top's ports and that clkEn stays high.
 */
`timescale 1ns/1ps
module msp_stats_phy_ctrl_properties
    import msp_pkg::*;
#(
    parameter logic [7:0] MEM_SIZE_UNITS = 8'h04
)(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        clkEn,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWrStb,
    input wire logic        regRdStb,
    input wire logic [15:0] regRdData,
    input wire logic        txPktDone,
    input wire logic        counterRolloverFlag,
    input wire logic        statsIrq,
    input wire logic        bufferManagerClearCmd
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------------
    sequence rdCnt;
        clkEn && regRdStb && regAddr == IDX_EVENT_CNT;
    endsequence
    // second read sees the cleared counters, no packet can sneak in
    sequence twoRd;
        (rdCnt ##0 !txPktDone) ##1 rdCnt;
    endsequence
    sequence wrRpcRd;
        (clkEn && regWrStb && regAddr == IDX_RX_PHY)
            ##1 (clkEn && regRdStb && regAddr == IDX_RX_PHY);
    endsequence

    AST_IRQ_MATCH: assert property (statsIrq == counterRolloverFlag)
        else $error("interrupt differs from rollover flag");
    AST_RD_CLEARS: assert property (twoRd |=> regRdData == 16'h0000)
        else $error("counters not cleared by read");
    AST_FLAG_CLEAR: assert property (
        twoRd |=> !counterRolloverFlag)
        else $error("rollover flag not cleared by read");
    AST_FLAG_SET: assert property (
        rdCnt ##1 (regRdData[15:12] == 4'hf
        || regRdData[11:8] == 4'hf || regRdData[7:4] == 4'hf
        || regRdData[3:0] == 4'hf) |-> $past(counterRolloverFlag))
        else $error("full counter without rollover flag");
    AST_STATUS_READ: assert property (clkEn && regRdStb
        && regAddr == IDX_STATUS |=>
        regRdData[STA_ROLL_BIT] == $past(counterRolloverFlag))
        else $error("status read shows wrong flag");
    AST_MEM_TOTAL: assert property (clkEn && regRdStb
        && regAddr == IDX_MEM_INFO |=> regRdData[7:0] == MEM_SIZE_UNITS)
        else $error("total memory field wrong");
    AST_MMU_PULSE: assert property (clkEn && regWrStb
        && regAddr == IDX_COMMAND && regWrData[CMD_MMU_CLR_BIT]
        |=> bufferManagerClearCmd ##1 !bufferManagerClearCmd)
        else $error("buffer manager clear pulse wrong");
    AST_RPC_READBACK: assert property (wrRpcRd |=>
        regRdData == ($past(regWrData, 2) & RPC_WMASK))
        else $error("control register readback wrong");
endmodule

bind msp_stats_phy_ctrl msp_stats_phy_ctrl_properties #(
    .MEM_SIZE_UNITS(MEM_SIZE_UNITS)
) i_msp_stats_phy_ctrl_properties (.*);

// ===== tb/msp_stats_phy_ctrl_test.sv
/*
 * Self-checking bench for the statistics and PHY control block.
 * Assumes the checker is bound in and the PHY model drives PHY levels.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module msp_stats_phy_ctrl_test
    import msp_pkg::*;
;
    localparam logic [7:0] MEMU = 8'h04;
    logic core_clk = 1'b0, reset = 1'b1, clkEn = 1'b1, regWrStb = 1'b0;
    logic regRdStb = 1'b0, txPktDone = 1'b0, txSuccess = 1'b0;
    logic txDeferred = 1'b0, txExcDeferred = 1'b0, memFreeValid = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000, regRdData;
    logic [4:0] txCollisions = 5'h00;
    logic [7:0] memFreeUnits = 8'h00;
    logic [8:0] phyCmd = 9'h000;
    logic phyAnegEnable, phyCtrlSpeed, phyCtrlDuplex, anegResultSpeed;
    logic anegResultDuplex, link10Pin, link100Pin, txActPin, rxActPin;
    logic phySpeed100, phyFullDuplex, phyAnegRun, counterRolloverFlag;
    logic statsIrq, bufferManagerClearCmd;
    logic indicatorOutFirst, indicatorOutSecond;
    logic [2:0] phyOut;
    assign phyOut = {phySpeed100, phyFullDuplex, phyAnegRun};
    int errors = 0, compares = 0;
    logic [31:0] rng = 32'd7911;
    logic [3:0] ex [4] = '{default: 4'h0};

    msp_stats_phy_ctrl #(.MEM_SIZE_UNITS(MEMU)) i_msp_stats_phy_ctrl (.*);
    msp_phy_model i_msp_phy_model (.core_clk, .cmd(phyCmd), .*);

    always #12.5 core_clk = ~core_clk;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic logic [3:0] sat(logic [3:0] v, logic e);
        return (e && v != 4'hf) ? v + 4'h1 : v;
    endfunction
    function automatic logic [2:0] phyExp(logic [15:0] r, logic [8:0] p);
        logic an;
        an = r[RPC_MAC_AUTONEG_SELECT_BIT];
        return {an ? (p[8] ? p[5] : p[7]) : r[RPC_SPEED_BIT],
                an ? (p[8] ? p[4] : p[6]) : r[RPC_DUPLEX_BIT], an & p[8]};
    endfunction
    function automatic logic ledExp(logic [2:0] c, logic [8:0] p, logic f);
        case (c)
            3'h0: return p[3] | p[2];
            3'h1: return 1'b0;
            3'h2: return p[3];
            3'h3: return f;
            3'h4: return p[1] | p[0];
            3'h5: return p[2];
            3'h6: return p[0];
            default: return p[1];
        endcase
    endfunction
    task automatic wr(logic [3:0] a, logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [15:0] d);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1 d = regRdData;
    endtask
    // leaves txPktDone high so packets may follow back to back
    task automatic pkt(logic s, logic [4:0] c, logic d, logic x);
        txPktDone <= 1'b1;
        txSuccess <= s;
        txCollisions <= c;
        txDeferred <= d;
        txExcDeferred <= x;
        @(posedge core_clk);
        ex[0] = sat(ex[0], s && c == 5'h01);
        ex[1] = sat(ex[1], c >= 5'h02 && c <= 5'h10);
        ex[2] = sat(ex[2], d);
        ex[3] = sat(ex[3], x);
    endtask
    task automatic chkCnt();
        logic [15:0] d;
        txPktDone <= 1'b0;
        rd(IDX_EVENT_CNT, d);
        `CHK(d, {ex[3], ex[2], ex[1], ex[0]})
        ex = '{default: 4'h0};
    endtask
    task automatic print_verdict();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #(25 * 6000);
        errors++;
        print_verdict();
    end

    initial begin
        logic [15:0] d;
        logic [15:0] r;
        logic fl;
        logic [2:0] px;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(IDX_RX_PHY, d);
        `CHK(d, RPC_RESET)
        rd(IDX_MEM_INFO, d);
        `CHK(d, {MEMU, MEMU})
        pkt(1'b0, 5'h01, 1'b0, 1'b0);
        pkt(1'b1, 5'h10, 1'b1, 1'b1);
        pkt(1'b1, 5'h11, 1'b0, 1'b0);
        txPktDone <= 1'b0;
        rd(4'h2, d);
        `CHK(d, 16'h0000)
        chkCnt();
        for (int i = 0; i < 70; i++) begin
            rng = xs(rng);
            pkt(rng[0], 5'(rng[12:8] % 17), rng[1], rng[2] & rng[3]);
            if (rng[4]) begin
                txPktDone <= 1'b0;
                @(posedge core_clk);
            end
            if (i == 9)
                chkCnt();
        end
        txPktDone <= 1'b0;
        repeat (3) @(posedge core_clk);
        fl = ex[0] == 4'hf || ex[1] == 4'hf || ex[2] == 4'hf || ex[3] == 4'hf;
        #1 `CHK(statsIrq, fl)
        `CHK(counterRolloverFlag, fl)
        rd(IDX_STATUS, d);
        `CHK(d[STA_ROLL_BIT], fl)
        chkCnt();
        chkCnt();
        regAddr <= IDX_EVENT_CNT;
        regRdStb <= 1'b1;
        pkt(1'b1, 5'h01, 1'b0, 1'b0);
        txPktDone <= 1'b0;
        regRdStb <= 1'b0;
        #1 `CHK(regRdData, 16'h0000)
        chkCnt();
        rd(IDX_STATUS, d);
        `CHK(d[STA_ROLL_BIT], 1'b0)
        for (int i = 0; i < 24; i++) begin
            rng = xs(rng);
            r = {rng[15:8], 3'(i), 3'(7 - i), rng[1:0]};
            phyCmd <= rng[24:16];
            wr(IDX_RX_PHY, r);
            rd(IDX_RX_PHY, d);
            `CHK(d, r & RPC_WMASK)
            wr(4'h4, 16'hffff);
            repeat (6) @(posedge core_clk);
            px = phyExp(r, phyCmd);
            #1 `CHK(phyOut, px)
            `CHK(indicatorOutFirst, ledExp(r[7:5], phyCmd, px[1]))
            `CHK(indicatorOutSecond, ledExp(r[4:2], phyCmd, px[1]))
        end
        memFreeUnits <= 8'h03;
        memFreeValid <= 1'b1;
        @(posedge core_clk);
        memFreeValid <= 1'b0;
        wr(IDX_MEM_INFO, 16'h0000);
        rd(IDX_MEM_INFO, d);
        `CHK(d, {8'h03, MEMU})
        wr(IDX_COMMAND, 16'h0001);
        #1 `CHK(bufferManagerClearCmd, 1'b1)
        repeat (2) @(posedge core_clk);
        rd(IDX_MEM_INFO, d);
        `CHK(d, {MEMU, MEMU})
        print_verdict();
    end
endmodule
